//--- design/wpr_filter.sv
// Purpose: synchronise and deglitch one serial line
// Assumes: input asynchronous to i_ref_clk
// Notes: output changes only after a level stays for the suppression time
`default_nettype none
module wpr_filter
   import wpr_pkg::*;
#(
   parameter int CYC = WPR_GLITCH_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_pin,
   output logic o_level
);
   typedef struct packed {
      logic [2:0] sync;
      logic [7:0] cnt;
      logic level;
   } wpr_flt_t;
   wpr_flt_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.sync = {s_q.sync[1:0], i_pin};
      // second and third stage agree and differ from output
      if (s_q.sync[1] == s_q.sync[2] && s_q.sync[2] != s_q.level) begin
         if (s_q.cnt >= 8'(CYC)) begin
            s_d.level = s_q.sync[2];
            s_d.cnt = 8'h00;
         end else begin
            s_d.cnt = s_q.cnt + 8'h01;
         end
      end else begin
         s_d.cnt = 8'h00;
      end
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         s_q <= '{sync: 3'b111, cnt: 8'h00, level: 1'b1};
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end
   assign o_level = s_q.level;
endmodule
`default_nettype wire

//--- design/wpr_pkg.sv
// Purpose: constants for the wiper position register block
// Assumes: 100 MHz i_ref_clk, serial clock sampled as a plain input
// Notes: tap select is one-hot, bit 0 nearest the low terminal
// How it works
// - 7-bit volatile register selects wiper tap
// - code zero picks tap nearest low terminal
// - all-ones code picks tap nearest high terminal
// - tap decode strictly monotonic with code
// - preset to mid-scale during power-up
// - recall stored initial byte into register
// - narrow pulses on serial lines rejected
// - top address read picks volatile or stored
// - top address write updates one or both
// - select bit is control msb, clears at power-up
// - all-ones address loads wiper on lsb fall
`default_nettype none
package wpr_pkg;
   localparam int WPR_WIDTH = 7;
   localparam int WPR_TAPS = 128;
   localparam logic [6:0] WPR_RESET = 7'h40;
   localparam logic [10:0] WPR_ADDR_WIPER = 11'h7FF;
   localparam logic [10:0] WPR_ADDR_CTRL = 11'h7FE;
   localparam int WPR_SEL_BIT = 7;
   localparam logic [3:0] WPR_ID_CODE = 4'hA;
   localparam int WPR_CLK_MHZ = 100;
   localparam int WPR_GLITCH_NS = 50;
   localparam int WPR_GLITCH_CYC = (WPR_GLITCH_NS * WPR_CLK_MHZ + 999) / 1000;
   localparam int WPR_SCL_MAX_KHZ = 400;
   localparam int WPR_NVW_MS = 12;
   localparam int WPR_NVW_CYC = WPR_NVW_MS * WPR_CLK_MHZ * 1000;
   localparam int WPR_PUP_MS = 3;
   localparam int WPR_PUP_CYC = WPR_PUP_MS * WPR_CLK_MHZ * 1000;
endpackage
`default_nettype wire

//--- design/wpr_top.sv
// Purpose: wiper position register with serial slave access
// Assumes: stored initial byte lives here as a register; write protect pin active low
// Notes: stored-byte write is self-timed, bus ignored meanwhile
`default_nettype none
module wpr_top
   import wpr_pkg::*;
#(
   parameter int NVW_CYC = WPR_NVW_CYC,
   parameter int PUP_CYC = WPR_PUP_CYC,
   parameter logic [6:0] STORE_INIT = 7'h40
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_wp_n,
   output logic o_sda,
   output logic o_sda_oe,
   output logic [WPR_WIDTH-1:0] o_wiper_position,
   output logic [WPR_TAPS-1:0] o_tap_select,
   output logic o_busy
);
   // ************************************************************
   // input conditioning
   // ************************************************************
   logic scl_f, sda_f, wp_f;
   wpr_filter u_scl (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_pin(i_scl), .o_level(scl_f));
   wpr_filter u_sda (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_pin(i_sda), .o_level(sda_f));
   // protect pin is asynchronous as well
   wpr_filter u_wp (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_pin(i_wp_n), .o_level(wp_f));

   typedef enum {ST_PUP, ST_IDLE, ST_ID, ST_ADDR, ST_DATA, ST_ACK, ST_RD, ST_RACK, ST_NVW} wpr_st_t;
   typedef struct packed {
      wpr_st_t st;
      wpr_st_t after_ack;
      logic scl;
      logic sda;
      logic [7:0] sh;
      logic [3:0] bits;
      logic [10:0] addr;
      logic rw;
      logic addr_done;
      logic [6:0] wiper;
      logic [6:0] store;
      logic [6:0] store_pend;
      logic pend;
      logic sel;
      logic [31:0] cnt;
      logic sda_o;
      logic oe;
      logic busy;
      logic [WPR_TAPS-1:0] tap;
   } wpr_state_t;
   wpr_state_t s_q, s_d;

   logic scl_rise, scl_fall, start_c, stop_c;
   assign scl_rise = scl_f & ~s_q.scl;
   assign scl_fall = ~scl_f & s_q.scl;
   assign start_c = scl_f & s_q.scl & s_q.sda & ~sda_f;
   assign stop_c = scl_f & s_q.scl & ~s_q.sda & sda_f;

   // ************************************************************
   // main state
   // ************************************************************
   always_comb begin
      logic [7:0] byte_in;
      logic [7:0] rd_byte;
      byte_in = 8'h00;
      rd_byte = 8'h00;
      s_d = s_q;
      s_d.scl = scl_f;
      s_d.sda = sda_f;
      byte_in = {s_q.sh[6:0], sda_f};
      if (s_q.addr == WPR_ADDR_WIPER) begin
         rd_byte = s_q.sel ? {1'b0, s_q.wiper} : {1'b0, s_q.store};
      end else if (s_q.addr == WPR_ADDR_CTRL) begin
         rd_byte = {s_q.sel, 7'h00};
      end else begin
         rd_byte = 8'h00;
      end
      case (s_q.st)
         ST_PUP: begin
            s_d.oe = 1'b0;
            if (s_q.cnt >= 32'(PUP_CYC)) begin
               s_d.wiper = s_q.store;
               s_d.cnt = 32'h0000_0000;
               s_d.st = ST_IDLE;
            end else begin
               s_d.cnt = s_q.cnt + 32'h0000_0001;
            end
         end
         ST_NVW: begin
            s_d.oe = 1'b0;
            if (s_q.cnt >= 32'(NVW_CYC)) begin
               s_d.store = s_q.store_pend;
               s_d.cnt = 32'h0000_0000;
               s_d.st = ST_IDLE;
            end else begin
               s_d.cnt = s_q.cnt + 32'h0000_0001;
            end
         end
         default: begin
            if (start_c) begin
               s_d.st = ST_ID;
               s_d.bits = 4'h0;
               s_d.oe = 1'b0;
               s_d.addr_done = 1'b0;
            end else if (stop_c) begin
               s_d.oe = 1'b0;
               s_d.st = s_q.pend ? ST_NVW : ST_IDLE;
               s_d.pend = 1'b0;
               s_d.cnt = 32'h0000_0000;
            end else begin
               case (s_q.st)
                  ST_ID, ST_ADDR, ST_DATA: begin
                     if (scl_rise) begin
                        s_d.sh = byte_in;
                        s_d.bits = s_q.bits + 4'h1;
                     end else if (scl_fall && s_q.bits == 4'h8) begin
                        s_d.bits = 4'h0;
                        s_d.sda_o = 1'b0;
                        s_d.oe = 1'b1;
                        s_d.st = ST_ACK;
                        if (s_q.st == ST_ID) begin
                           s_d.rw = s_q.sh[0];
                           s_d.addr = {s_q.sh[3:1], s_q.addr[7:0]};
                           if (s_q.sh[7:4] != WPR_ID_CODE) begin
                              s_d.oe = 1'b0;
                              s_d.st = ST_IDLE;
                           end
                           s_d.after_ack = s_q.sh[0] ? ST_RD : ST_ADDR;
                        end else if (s_q.st == ST_ADDR) begin
                           s_d.addr = {s_q.addr[10:8], s_q.sh};
                           s_d.after_ack = ST_DATA;
                        end else if (!wp_f) begin
                           s_d.oe = 1'b0;
                           s_d.st = ST_IDLE;
                        end else begin
                           if (s_q.addr == WPR_ADDR_CTRL) begin
                              s_d.sel = s_q.sh[WPR_SEL_BIT];
                           end else if (s_q.addr == WPR_ADDR_WIPER && !s_q.sel) begin
                              s_d.store_pend = s_q.sh[6:0];
                              s_d.pend = 1'b1;
                           end else if (s_q.addr != WPR_ADDR_WIPER) begin
                              s_d.pend = 1'b1;
                           end
                           s_d.addr = {s_q.addr[10:4], s_q.addr[3:0] + 4'h1};
                           s_d.after_ack = ST_DATA;
                        end
                     end
                  end
                  ST_ACK: begin
                     if (scl_fall) begin
                        s_d.oe = 1'b0;
                        s_d.st = s_q.after_ack;
                        if (s_q.after_ack == ST_RD) begin
                           s_d.sh = rd_byte;
                           s_d.sda_o = rd_byte[7];
                           s_d.oe = ~rd_byte[7];
                           s_d.bits = 4'h1;
                        end
                     end
                  end
                  ST_RD: begin
                     if (scl_fall) begin
                        if (s_q.bits == 4'h8) begin
                           s_d.oe = 1'b0;
                           s_d.st = ST_RACK;
                        end else begin
                           s_d.sh = {s_q.sh[6:0], 1'b0};
                           s_d.oe = ~s_q.sh[6];
                           s_d.bits = s_q.bits + 4'h1;
                        end
                     end
                  end
                  ST_RACK: begin
                     if (scl_rise) begin
                        s_d.st = sda_f ? ST_IDLE : ST_RACK;
                        s_d.addr = s_q.addr + 11'h001;
                     end else if (scl_fall) begin
                        s_d.sh = rd_byte;
                        s_d.oe = ~rd_byte[7];
                        s_d.bits = 4'h1;
                        s_d.st = ST_RD;
                     end
                  end
                  default: s_d.oe = 1'b0;
               endcase
            end
         end
      endcase
      // wiper load on falling edge after data lsb, gated by protect pin
      if (s_q.st == ST_DATA && scl_fall && s_q.bits == 4'h8 && wp_f && s_q.addr == WPR_ADDR_WIPER) begin
         s_d.wiper = s_q.sh[6:0];
      end
      // one-hot decode: tap index equals code
      s_d.tap = '0;
      s_d.tap[s_d.wiper] = 1'b1;
      // busy registered alongside the state so the output comes from a flop
      s_d.busy = (s_d.st == ST_NVW) || (s_d.st == ST_PUP);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         s_q <= '0;
         s_q.st <= ST_PUP;
         s_q.after_ack <= ST_IDLE;
         s_q.scl <= 1'b1;
         s_q.sda <= 1'b1;
         s_q.wiper <= WPR_RESET;
         s_q.store <= STORE_INIT;
         s_q.sel <= 1'b0;
         s_q.busy <= 1'b1;
         s_q.tap <= WPR_TAPS'(1) << WPR_RESET;
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   assign o_sda = s_q.sda_o & 1'b0;
   assign o_sda_oe = s_q.oe;
   assign o_wiper_position = s_q.wiper;
   assign o_tap_select = s_q.tap;
   assign o_busy = s_q.busy;
endmodule
`default_nettype wire

//--- tb/wiper_position_register_test.sv
// Purpose: self-checking bench for the wiper register
// Assumes: short power-up and write counts
// Notes: model keeps wiper, stored byte and select bit
`default_nettype none
module wiper_position_register_test
   import wpr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [6:0] INIT = 7'h25;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wp_n = 1'b1, scl, h_sda, o_sda, oe, busy, sel;
   logic [6:0] wiper, exp_w, exp_s;
   logic [127:0] tap;
   logic [7:0] q, d;
   logic [31:0] seed = 32'h07ce;
   int err_count = 0, checked = 0;
   wire logic sda = h_sda & (!oe | o_sda);
   // ********
   // harness
   // ********
   always #5 clk = ~clk;
   wpr_top #(.NVW_CYC(50), .PUP_CYC(50), .STORE_INIT(INIT)) i_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_ce(ce),
      .i_scl(scl), .i_sda(sda), .i_wp_n(wp_n), .o_sda(o_sda), .o_sda_oe(oe), .o_wiper_position(wiper),
      .o_tap_select(tap), .o_busy(busy));
   wpr_host i_host (.o_scl(scl), .o_sda(h_sda), .i_sda(sda));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      // let the line filters see the stop before busy is polled
      repeat (20) @(negedge clk);
      while (busy !== 1'b0 && n < 500) begin
         @(negedge clk);
         n++;
      end
      if (n >= 500) begin
         err_count++;
         test_done();
      end
   endtask
   task automatic addr(input logic [10:0] a, input logic rw);
      logic ack;
      i_host.start();
      i_host.byte_io({4'hA, a[10:8], rw}, q, ack);
      chk(ack, 1);
      if (!rw) begin
         i_host.byte_io(a[7:0], q, ack);
         chk(ack, 1);
      end
   endtask
   task automatic rd(input logic [10:0] a, input logic [7:0] exp);
      logic ack;
      addr(a, 1'b0);
      i_host.stop();
      wait_idle();
      addr(a, 1'b1);
      i_host.byte_io(8'hFF, q, ack);
      i_host.stop();
      chk(q, exp);
      wait_idle();
   endtask
   task automatic wr(input logic [10:0] a, input logic [7:0] dat, input logic ok);
      logic ack;
      addr(a, 1'b0);
      i_host.byte_io(dat, q, ack);
      chk(ack, ok);
      i_host.stop();
      wait_idle();
      if (ok && a == WPR_ADDR_CTRL)
         sel = dat[7];
      if (ok && a == WPR_ADDR_WIPER) begin
         exp_w = dat[6:0];
         if (!sel)
            exp_s = dat[6:0];
      end
      chk(wiper, exp_w);
      chk(tap === (128'h1 << exp_w), 1);
      rd(WPR_ADDR_WIPER, {1'b0, (sel ? exp_w : exp_s)});
   endtask
   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      chk(wiper, WPR_RESET);
      chk(busy, 1);
      {exp_w, exp_s, sel} = {INIT, INIT, 1'b0};
      wait_idle();
      wr(WPR_ADDR_CTRL, 8'h00, 1'b1);
      $display("power-up test done");
      wr(WPR_ADDR_CTRL, 8'h80, 1'b1);
      rd(WPR_ADDR_CTRL, 8'h80);
      for (int k = 0; k < 5; k++) begin
         seed = lfsr(seed);
         d = (k == 0) ? 8'h00 : (k == 1) ? 8'h7F : {1'b0, seed[6:0]};
         i_host.glitch = (k == 4);
         wr(WPR_ADDR_WIPER, d, 1'b1);
      end
      i_host.glitch = 1'b0;
      $display("volatile write test done");
      wr(WPR_ADDR_CTRL, 8'h00, 1'b1);
      seed = lfsr(seed);
      wr(WPR_ADDR_WIPER, {1'b0, seed[6:0]}, 1'b1);
      wr(11'h010, 8'h5A, 1'b1);
      $display("stored write test done");
      wp_n = 1'b0;
      wr(WPR_ADDR_WIPER, {1'b0, ~seed[6:0]}, 1'b0);
      wp_n = 1'b1;
      ce = 1'b0;
      repeat (4) @(negedge clk);
      ce = 1'b1;
      chk(wiper, exp_w);
      $display("protect and freeze test done");
      test_done();
   end
endmodule
bind wpr_top wpr_top_chk #(.PUP_CYC(PUP_CYC), .STORE_INIT(STORE_INIT)) i_chk (.i_ref_clk(i_ref_clk),
   .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_scl(i_scl), .i_wp_n(i_wp_n), .o_sda_oe(o_sda_oe),
   .o_wiper_position(o_wiper_position), .o_tap_select(o_tap_select), .o_busy(o_busy));
`default_nettype wire

//--- tb/wpr_host.sv
// Purpose: serial bus master model
// Assumes: pull-up on the data line, resolved in the bench
// Notes: phase time scaled down, glitch adds a narrow clock pulse
`default_nettype none
module wpr_host (
   output var logic o_scl,
   output var logic o_sda,
   input wire logic i_sda
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int PH = 80;
   logic glitch = 1'b0;
   // ********
   // bus tasks
   // ********
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   task automatic start();
      o_sda = 1'b0;
      #PH;
      o_scl = 1'b0;
      #PH;
   endtask
   task automatic stop();
      o_sda = 1'b0;
      #PH;
      o_scl = 1'b1;
      #PH;
      o_sda = 1'b1;
      #PH;
   endtask
   task automatic bit_io(input logic b, output logic r);
      o_sda = b;
      if (glitch) begin
         #20 o_scl = 1'b1;
         #20 o_scl = 1'b0;
         #40;
      end else begin
         #PH;
      end
      o_scl = 1'b1;
      #PH;
      r = i_sda;
      o_scl = 1'b0;
      #PH;
   endtask
   task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(1'b1, r);
      ack = !r;
   endtask
endmodule
`default_nettype wire

//--- tb/wpr_top_chk.sv
// Purpose: port assertions for the wiper register block
// Assumes: scl fall age is counted from the raw pin
// Notes: bound from the bench top file
`default_nettype none
module wpr_top_chk
   import wpr_pkg::*;
#(
   parameter int PUP_CYC = 50,
   parameter logic [6:0] STORE_INIT = 7'h40
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_scl,
   input wire logic i_wp_n,
   input wire logic o_sda_oe,
   input wire logic [WPR_WIDTH-1:0] o_wiper_position,
   input wire logic [WPR_TAPS-1:0] o_tap_select,
   input wire logic o_busy
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int PUP_HI = PUP_CYC + 20;
   logic scl_q;
   logic [4:0] age_q;
   // ********
   // checks
   // ********
   always_ff @(posedge i_ref_clk) begin
      scl_q <= i_scl;
      if (i_sys_rst)
         age_q <= 5'h1F;
      else if (scl_q && !i_scl)
         age_q <= 5'h0;
      else if (age_q != 5'h1F)
         age_q <= age_q + 5'h1;
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   a_tap_decode: assert property (o_tap_select == (128'h1 << o_wiper_position))
      else $error("tap select off code");
   a_reset_preset: assert property (disable iff (1'b0) i_sys_rst |=> o_wiper_position == WPR_RESET)
      else $error("no mid-scale preset");
   a_pup_hold: assert property ($fell(i_sys_rst) |-> (o_busy && o_wiper_position == WPR_RESET)[*8])
      else $error("preset not held");
   a_recall_load: assert property ($fell(i_sys_rst) |-> ##[1:PUP_HI] (!o_busy && o_wiper_position == STORE_INIT))
      else $error("no recall");
   a_wiper_cause: assert property ($changed(o_wiper_position) |-> $past(o_busy) || age_q <= 5'h10)
      else $error("wiper moved without cause");
   a_ce_freeze: assert property (!i_ce |=> $stable(o_wiper_position) && $stable(o_sda_oe))
      else $error("state moved while frozen");
   a_busy_quiet: assert property (o_busy |-> !o_sda_oe)
      else $error("bus driven while busy");
   a_wp_guard: assert property (!i_wp_n && !o_busy |=> $stable(o_wiper_position))
      else $error("protected write moved wiper");
   c_recall: cover property ($fell(o_busy));
   c_write: cover property ($changed(o_wiper_position) && !o_busy);
   c_ack: cover property ($rose(o_sda_oe));
endmodule
`default_nettype wire
